// File: tdc_counter.sv
// Trip direction change counter: lifetime total, limited counter with
// password, warning, lockout, restart grace trip and clear history.
// Assumes trip commands and day ticks synchronous to i_clk; persistent
// storage is modelled by registers that only the power-on reset loads.
//
// Behaviour
// - Count only trips reversing direction, and the first trip
// - Lifetime total never cleared by software
// - Password guards maximum change and clear
// - Warn with remaining trips one year ahead
// - Usage rate raised by each trip that exceeds it, reloaded each year
// - Fault output at maximum reached
// - Refuse trip commands while at maximum
// - One extra trip after each restart
// - Log every clear in persistent history
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module tdc_counter
    import tdc_pkg::*;
(
    input  wire logic        i_clk,        // 10 MHz
    input  wire logic        i_rst_b,      // Async power-on reset
    input  wire logic        i_en,         // Clock enable, freezes all state
    input  wire logic        i_restart,    // Inverter restart pulse (warm)
    input  wire logic        i_trip_req,   // Trip command pulse
    input  wire logic        i_trip_dir,   // Requested direction, 1 = up
    input  wire logic        i_day_tick,   // One pulse per day
    input  wire logic        i_restore_we, // Load limited counter from old unit
    input  wire logic [31:0] i_restore_val,// Value copied from old unit
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic             o_trip_go,    // Trip accepted pulse
    output logic             o_trip_refused,// Trip refused pulse
    output logic             o_fault,      // Fault output at limit
    output logic             o_warn,       // Show remaining trips
    output logic      [31:0] o_remaining,  // Trips left for display
    output logic             o_irq
);
    // Counters and configuration; power-on reset loads them all, restart also loads grace_q and unlock_q
    logic [31:0]     total_q;      // Lifetime total
    logic [31:0]     limit_cnt_q;  // Limited trip counter
    logic [31:0]     max_q;        // Permitted maximum
    logic [31:0]     pw_q;         // Stored password
    logic            unlock_q;     // Password accepted
    logic            lock_q;       // Lockout flag
    logic            grace_q;      // Extra trip available after restart
    logic            last_dir_q;   // Direction of previous trip
    logic            dir_valid_q;  // A previous trip exists
    logic [31:0]     rate_q;       // Trips per year estimate
    logic [31:0]     year_trips_q; // Trips in current window
    logic [15:0]     day_cnt_q;    // Days in current window
    logic [31:0]     hist_cnt_q;   // Clears logged
    logic [31:0]     last_clr_q;   // Counter value at last clear
    logic [EV_N-1:0] int_stat_q;
    logic [EV_N-1:0] int_mask_q;
    // Combinational helpers
    logic [EV_N-1:0] ev;
    logic            warn_now;
    logic [31:0]     remain;
    logic            accept;
    logic            refuse;
    logic            counts;
    logic            clear_ok;
    logic            wr_ctrl;

    // Trip acceptance: blocked while locked unless grace trip is held
    assign accept   = i_trip_req && (!lock_q || grace_q);
    assign refuse   = i_trip_req && !accept;
    // Only a direction change, or the first trip, adds a count
    assign counts   = accept && (!dir_valid_q || i_trip_dir != last_dir_q);
    assign wr_ctrl  = i_wr && i_addr == ADDR_CTRL;
    assign clear_ok = wr_ctrl && i_wdata[CTRL_CLEAR] && unlock_q;
    assign remain   = (max_q > limit_cnt_q) ? max_q - limit_cnt_q : 32'h0000_0000;
    // Warning when remaining trips fall within one year's usage
    assign warn_now = !lock_q && rate_q != 32'h0000_0000 && remain <= rate_q;

    // Lifetime total: only power-on reset, no software path
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            total_q <= 32'h0000_0000;
        else if (i_en && counts)
            total_q <= total_q + 32'h0000_0001;
    end

    // Limited counter: counts, cleared with password or restored
    // Restore beats clear so a unit swap is never lost to a stray clear
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            limit_cnt_q <= 32'h0000_0000;
        else if (i_en)
        begin
            if (i_restore_we)
                limit_cnt_q <= i_restore_val;
            else if (clear_ok)
                limit_cnt_q <= 32'h0000_0000;
            else if (counts)
                limit_cnt_q <= limit_cnt_q + 32'h0000_0001;
        end
    end

    // Lockout flag: set when counter reaches or exceeds maximum, held until a permitted clear
    // Compared on every edge, so a lowered maximum also locks
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            lock_q <= 1'b0;
        else if (i_en)
        begin
            if (clear_ok)
                lock_q <= 1'b0;
            else if (limit_cnt_q >= max_q)
                lock_q <= 1'b1;
        end
    end

    // Grace trip: granted per restart, spent by one trip accepted while locked
    // A restart wins over a spend in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            grace_q <= 1'b1;
        else if (i_en)
        begin
            if (i_restart)
                grace_q <= 1'b1;
            else if (accept && lock_q)
                grace_q <= 1'b0;
        end
    end

    // Previous direction memory
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            last_dir_q  <= 1'b0;
            dir_valid_q <= 1'b0;
        end
        else if (i_en && accept)
        begin
            last_dir_q  <= i_trip_dir;
            dir_valid_q <= 1'b1;
        end
    end

    // Maximum and password: writes need an accepted password
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            max_q    <= MAX_RESET;
            pw_q     <= PW_RESET;
            unlock_q <= 1'b0;
        end
        else if (i_en)
        begin
            if (i_wr && i_addr == ADDR_MAX && unlock_q)
                max_q <= i_wdata;
            if (wr_ctrl && i_wdata[CTRL_SET_PW] && unlock_q)
                pw_q <= i_wdata;
            if (i_restart || (wr_ctrl && i_wdata[CTRL_LOCK]))
                unlock_q <= 1'b0;
            else if (i_wr && i_addr == ADDR_PASSWORD)
                unlock_q <= (i_wdata == pw_q);
        end
    end

    // Usage history: trips over consecutive fixed year windows
    // Estimate starts at zero and follows the window count once exceeded, so a warning can show in the first year
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rate_q       <= RATE_RESET;
            year_trips_q <= 32'h0000_0000;
            day_cnt_q    <= 16'h0000;
        end
        else if (i_en)
        begin
            if (i_day_tick && day_cnt_q == YEAR_DAYS_W - 16'h0001)
            begin
                day_cnt_q    <= 16'h0000;
                year_trips_q <= 32'h0000_0000;
                rate_q       <= year_trips_q;
            end
            else
            begin
                if (i_day_tick)
                    day_cnt_q <= day_cnt_q + 16'h0001;
                if (counts)
                begin
                    year_trips_q <= year_trips_q + 32'h0000_0001;
                    // Refresh estimate after each trip once exceeded
                    if (year_trips_q >= rate_q)
                        rate_q <= year_trips_q + 32'h0000_0001;
                end
            end
        end
    end

    // Clear history log
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            hist_cnt_q <= 32'h0000_0000;
            last_clr_q <= 32'h0000_0000;
        end
        else if (i_en && clear_ok)
        begin
            hist_cnt_q <= hist_cnt_q + 32'h0000_0001;
            last_clr_q <= limit_cnt_q;
        end
    end

    // Event sources
    assign ev[EV_TRIP]    = counts;
    assign ev[EV_WARN]    = warn_now && !o_warn;
    assign ev[EV_LIMIT]   = limit_cnt_q >= max_q && !lock_q;
    assign ev[EV_REFUSED] = refuse;
    assign ev[EV_CLEARED] = clear_ok;
    assign ev[EV_BADPW]   = i_wr && i_addr == ADDR_PASSWORD && i_wdata != pw_q;

    // Sticky events, write one to clear, a new set wins
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            int_stat_q <= '0;
            int_mask_q <= '0;
        end
        else if (i_en)
        begin
            if (i_wr && i_addr == ADDR_INT_MASK)
                int_mask_q <= i_wdata[EV_N-1:0];
            if (i_wr && i_addr == ADDR_INT_STAT)
                int_stat_q <= (int_stat_q & ~i_wdata[EV_N-1:0]) | ev;
            else
                int_stat_q <= int_stat_q | ev;
        end
    end

    // Registered outputs
    // Fault lags the lock flag by one cycle, as do warn and remaining
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_trip_go      <= 1'b0;
            o_trip_refused <= 1'b0;
            o_fault        <= 1'b0;
            o_warn         <= 1'b0;
            o_remaining    <= 32'h0000_0000;
            o_irq          <= 1'b0;
        end
        else if (i_en)
        begin
            o_trip_go      <= accept;
            o_trip_refused <= refuse;
            o_fault        <= lock_q;
            o_warn         <= warn_now;
            o_remaining    <= remain;
            o_irq          <= |(int_stat_q & int_mask_q);
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_rdata <= 32'h0000_0000;
        else if (i_en)
        begin
            if (!i_rd)
                o_rdata <= 32'h0000_0000;
            else
            begin
                // Status: grace, unlock, warn, then lock in both low bits
                unique case (i_addr)
                    ADDR_TOTAL:     o_rdata <= total_q;
                    ADDR_LIMIT_CNT: o_rdata <= limit_cnt_q;
                    ADDR_MAX:       o_rdata <= max_q;
                    ADDR_STATUS:    o_rdata <= {27'h0, grace_q, unlock_q, warn_now,
                                                lock_q, lock_q};
                    ADDR_REMAIN:    o_rdata <= remain;
                    ADDR_INT_STAT:  o_rdata <= {26'h0, int_stat_q};
                    ADDR_INT_MASK:  o_rdata <= {26'h0, int_mask_q};
                    ADDR_CLR_HIST:  o_rdata <= hist_cnt_q;
                    ADDR_LAST_CLR:  o_rdata <= last_clr_q;
                    ADDR_RATE:      o_rdata <= rate_q;
                    // Password never reads back; unmapped reads zero
                    default:        o_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // tdc_counter

// File: tdc_pkg.sv
// Package for the trip direction change counter block.
// Assumes a single 10 MHz clock domain and a plain register port.
package tdc_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0]  ADDR_TOTAL     = 8'h00; // Lifetime total, read only
    localparam logic [7:0]  ADDR_LIMIT_CNT = 8'h04; // Limited trip counter, read only
    localparam logic [7:0]  ADDR_MAX       = 8'h08; // Permitted maximum
    localparam logic [7:0]  ADDR_PASSWORD  = 8'h0C; // Password entry, compared with stored password
    localparam logic [7:0]  ADDR_CTRL      = 8'h10; // Control commands
    localparam logic [7:0]  ADDR_STATUS    = 8'h14; // Live status
    localparam logic [7:0]  ADDR_REMAIN    = 8'h18; // Trips remaining
    localparam logic [7:0]  ADDR_INT_STAT  = 8'h1C; // Sticky events, write one to clear
    localparam logic [7:0]  ADDR_INT_MASK  = 8'h20; // Event enables
    localparam logic [7:0]  ADDR_CLR_HIST  = 8'h24; // Number of clears logged
    localparam logic [7:0]  ADDR_LAST_CLR  = 8'h28; // Counter value at last clear
    localparam logic [7:0]  ADDR_RATE      = 8'h2C; // Trips per year estimate
    // Control field positions
    localparam int          CTRL_UNLOCK    = 0;     // Unused; password compared on ADDR_PASSWORD write
    localparam int          CTRL_CLEAR     = 1;     // Clear limited counter
    localparam int          CTRL_LOCK      = 2;     // Drop unlock
    localparam int          CTRL_SET_PW    = 3;     // Store new password
    // Interrupt status / event field positions
    localparam int          EV_TRIP        = 0;
    localparam int          EV_WARN        = 1;
    localparam int          EV_LIMIT       = 2;
    localparam int          EV_REFUSED     = 3;
    localparam int          EV_CLEARED     = 4;
    localparam int          EV_BADPW       = 5;
    localparam int          EV_N           = 6;
    // Reset values
    localparam logic [31:0] MAX_RESET      = 32'h000F_4240;
    localparam logic [31:0] PW_RESET       = 32'h0000_0000;
    localparam logic [31:0] RATE_RESET     = 32'h0000_0000;
    // Usage estimate: rate is trips in one year, raised by each trip beyond it
    localparam int          YEAR_DAYS      = 365;
    localparam logic [15:0] YEAR_DAYS_W    = 16'(YEAR_DAYS);
endpackage : tdc_pkg

// File: tdc_counter_asserts.sv
// Checker for the trip counter block, watching its ports only.
// Assumes one clock domain; bound to every tdc_counter instance.
`timescale 1ns/100ps
module tdc_counter_asserts
    import tdc_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_en,
    input wire logic        i_trip_req,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        o_trip_go,
    input wire logic        o_trip_refused,
    input wire logic        o_fault,
    input wire logic        o_warn,
    input wire logic [31:0] o_remaining
);
    // All checks share the one clock and the power-on reset
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    chk_trip_answer: assert property
        (i_en && i_trip_req |=> o_trip_go != o_trip_refused) else $error("trip unanswered");
    chk_answer_cause: assert property
        ((o_trip_go || o_trip_refused) |-> $past(i_trip_req && i_en)) else $error("stray answer");
    chk_refuse_fault: assert property
        (o_trip_refused |-> o_fault) else $error("refused while not at limit");
    // Lockout only drops through a register write a few cycles earlier
    chk_fault_held: assert property
        ($fell(o_fault) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3))
        else $error("fault dropped without clear");
    chk_fault_empty: assert property
        ($rose(o_fault) |-> o_remaining == 32'h0) else $error("fault with trips left");
    chk_warn_lock: assert property
        (!(o_warn && o_fault)) else $error("warning while locked");
    chk_rdata_idle: assert property
        (!$past(i_rd && i_en) |-> o_rdata == 32'h0) else $error("read data outside slot");
    chk_freeze_hold: assert property
        (!i_en |=> $stable(o_remaining) && $stable(o_fault)) else $error("state moved when frozen");
endmodule // tdc_counter_asserts

bind tdc_counter tdc_counter_asserts u_chk
(
    .i_clk, .i_rst_b, .i_en, .i_trip_req, .i_wr, .i_rd, .o_rdata,
    .o_trip_go, .o_trip_refused, .o_fault, .o_warn, .o_remaining
);

// File: tdc_lift_ctrl.sv
// Lift control model: issues one trip command per bench request.
// Assumes the trip answer pulses of tdc_counter on the same clock.
`timescale 1ns/100ps
module tdc_lift_ctrl
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_go,           // Bench asks for a trip
    input  wire logic       i_dir,          // Direction of that trip
    input  wire logic       i_trip_go,
    input  wire logic       i_trip_refused,
    output logic            o_trip_req,
    output logic            o_trip_dir,
    output logic      [1:0] o_answer        // {refused, accepted} of last trip
);
    // One-cycle command; direction toggles outside it so stale values never help
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_trip_req <= 1'h0;
            o_trip_dir <= 1'h0;
        end
        else
        begin
            o_trip_req <= i_go;
            o_trip_dir <= i_go ? i_dir : ~o_trip_dir;
        end
    end
    // Latch the answer; a new command wipes it
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_answer <= 2'h0;
        else if (i_go)
            o_answer <= 2'h0;
        else if (i_trip_go || i_trip_refused)
            o_answer <= {i_trip_refused, i_trip_go};
    end
endmodule // tdc_lift_ctrl

// File: trip_direction_change_counter_tb_top.sv
// Testbench: register and trip tasks driving tdc_counter and a lift model.
// Assumes the checker bind and tdc_lift_ctrl are compiled before it.
`timescale 1ns/100ps
module trip_direction_change_counter_tb_top;
    import tdc_pkg::*;
    logic        clk = 1'h0;          // 10 MHz
    logic        rst_b = 1'h0;        // Power-on reset
    logic        en = 1'h1;
    logic        restart = 1'h0;
    logic        go = 1'h0;
    logic        dir = 1'h0;
    logic        day = 1'h0;          // Day pulse for the usage window
    logic        rst_we = 1'h0;       // Unit swap load
    logic [31:0] rst_val = 32'h0;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'h0;
    logic        rd = 1'h0;
    logic [31:0] rdata, remaining;
    logic        trip_go, trip_ref, fault, warn, irq, req, tdir;
    logic [1:0]  ans;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #50 clk = ~clk;

    tdc_counter DUT (.i_clk(clk), .i_rst_b(rst_b), .i_en(en), .i_restart(restart),
        .i_trip_req(req), .i_trip_dir(tdir), .i_day_tick(day), .i_restore_we(rst_we),
        .i_restore_val(rst_val), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_trip_go(trip_go), .o_trip_refused(trip_ref), .o_fault(fault),
        .o_warn(warn), .o_remaining(remaining), .o_irq(irq));
    tdc_lift_ctrl u_lift (.i_clk(clk), .i_rst_b(rst_b), .i_go(go), .i_dir(dir),
        .i_trip_go(trip_go), .i_trip_refused(trip_ref), .o_trip_req(req),
        .o_trip_dir(tdir), .o_answer(ans));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    // Read data only stand in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 check(n, rdata, e);
    endtask
    // Trip through the lift model; lockout needs four edges to show
    task automatic trip(input logic d, input logic [1:0] e);
        @(posedge clk);
        go <= 1'h1;
        dir <= d;
        @(posedge clk);
        go <= 1'h0;
        repeat (4) @(posedge clk);
        #1 check("answer", {30'h0, ans}, {30'h0, e});
    endtask
    // Single day pulses with a gap cycle between them
    task automatic day_ticks(input int n);
        repeat (n)
        begin
            @(posedge clk);
            day <= 1'h1;
            @(posedge clk);
            day <= 1'h0;
        end
    endtask
    task automatic test_done;
        $display("Checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard, well above the roughly 1600 cycles the sequence needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            test_done();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'h1;
        en <= 1'h0;
        repeat (3) @(posedge clk);
        en <= 1'h1;
        rd_reg(8'h30, 32'h0, "unmapped");
        wr_reg(ADDR_MAX, 32'h4);
        rd_reg(ADDR_MAX, MAX_RESET, "max locked");
        wr_reg(ADDR_PASSWORD, 32'h5);
        rd_reg(ADDR_INT_STAT, 32'h20, "bad pw");
        wr_reg(ADDR_PASSWORD, PW_RESET);
        wr_reg(ADDR_CTRL, 32'h8);
        wr_reg(ADDR_CTRL, 32'h4);
        wr_reg(ADDR_MAX, 32'h7);
        wr_reg(ADDR_PASSWORD, 32'h8);
        rd_reg(ADDR_MAX, MAX_RESET, "max relocked");
        wr_reg(ADDR_MAX, 32'h4);
        rd_reg(ADDR_MAX, 32'h4, "max");
        wr_reg(ADDR_INT_STAT, 32'h20);
        for (int i = 0; i < 5; i++)
            trip(1'(5'h13 >> i), 2'h1);
        rd_reg(ADDR_TOTAL, 32'h3, "total");
        rd_reg(ADDR_LIMIT_CNT, 32'h3, "limit cnt");
        rd_reg(ADDR_RATE, 32'h3, "rate");
        check("remaining", remaining, 32'h1);
        check("warn", {31'h0, warn}, 32'h1);
        rd_reg(ADDR_INT_STAT, 32'h3, "events");
        check("irq masked", {31'h0, irq}, 32'h0);
        wr_reg(ADDR_INT_MASK, 32'h4);
        wr_reg(ADDR_INT_STAT, 32'h3);
        trip(1'h0, 2'h1);
        check("fault", {31'h0, fault}, 32'h1);
        check("irq", {31'h0, irq}, 32'h1);
        check("warn locked", {31'h0, warn}, 32'h0);
        trip(1'h0, 2'h1);
        trip(1'h0, 2'h2);
        wr_reg(ADDR_INT_STAT, 32'h4);
        rd_reg(ADDR_LIMIT_CNT, 32'h4, "held cnt");
        check("irq clear", {31'h0, irq}, 32'h0);
        @(posedge clk);
        restart <= 1'h1;
        @(posedge clk);
        restart <= 1'h0;
        trip(1'h0, 2'h1);
        trip(1'h1, 2'h2);
        rd_reg(ADDR_TOTAL, 32'h4, "total kept");
        wr_reg(ADDR_CTRL, 32'h2);
        rd_reg(ADDR_LIMIT_CNT, 32'h4, "no clear");
        wr_reg(ADDR_PASSWORD, 32'h8);
        wr_reg(ADDR_CTRL, 32'h2);
        rd_reg(ADDR_LIMIT_CNT, 32'h0, "cleared");
        rd_reg(ADDR_CLR_HIST, 32'h1, "clr hist");
        rd_reg(ADDR_LAST_CLR, 32'h4, "last clr");
        check("fault off", {31'h0, fault}, 32'h0);
        trip(1'h1, 2'h1);
        rd_reg(ADDR_TOTAL, 32'h5, "total");
        @(posedge clk);
        rst_val <= 32'h2;
        rst_we <= 1'h1;
        @(posedge clk);
        rst_we <= 1'h0;
        rd_reg(ADDR_LIMIT_CNT, 32'h2, "restored");
        // Two year windows: the second holds one trip, so the estimate drops to it
        day_ticks(YEAR_DAYS);
        trip(1'h0, 2'h1);
        day_ticks(YEAR_DAYS);
        rd_reg(ADDR_RATE, 32'h1, "rate year");
        test_done();
    end
endmodule // trip_direction_change_counter_tb_top
